// file: hw/fault_mgr_pkg.sv
// fault manager package: codes, action encodings, sync depth
// assumes a single system clock domain
`default_nettype none
package fault_mgr_pkg;
  localparam int CODE_W = 7;
  // warning codes whose outputs the warning setting may suppress
  localparam logic [6:0] QUIET_LO = 7'h56; // 86
  localparam logic [6:0] QUIET_HI = 7'h5e; // 94
  localparam int ACT_W = 2;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_RUN = 2'h0;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] FLASH_RST = 2'h0;
  typedef enum {
    ST_IDLE,
    ST_RAISED,
    ST_SILENCED
  } fault_state_t;
endpackage : fault_mgr_pkg
`default_nettype wire

// file: hw/pin_sync.sv
// two flop synchroniser for a bus of asynchronous levels
// assumes the levels are slow compared with the clock
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_reg;
  // first stage feeds only the second stage
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= '0;
      q_out <= '0;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule : pin_sync
`default_nettype wire

// file: hw/pump_alarm_warning_manager.sv
// pump fault manager: sorts faults, drives lamp, outputs, buzzer, log
// assumes fault inputs and buttons are asynchronous pins; log and
// action consumers run on CLK_IN
`default_nettype none
module pump_alarm_warning_manager
  import fault_mgr_pkg::*;
#(
  parameter int FLASH_DIV = 5000000, // half period of lamp flash in cycles
  parameter logic [ACT_W*128-1:0] ACTION_MAP = '0 // action per alarm code
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic ALARM_DET_IN,       // alarm-class fault present
  input wire logic WARN_DET_IN,        // warning-class fault present
  input wire logic [CODE_W-1:0] CODE_IN, // code of present fault
  input wire logic SURGE_IN,           // rapid vacuum pressure rise
  input wire logic RESET_CMD_IN,       // operator reset button or remote
  input wire logic WARN_OUT_EN_IN,     // warning output menu setting
  output logic LAMP_OUT,
  output logic ALARM_OUT,
  output logic WARNING_OUT,
  output logic BUZZER_OUT,
  output logic BRAKE_OUT,
  output logic DISPLAY_VALID_OUT,
  output logic [CODE_W-1:0] DISPLAY_CODE_OUT,
  output logic [ACT_W-1:0] ACTION_OUT,
  output logic LOG_WR_OUT,
  output logic [CODE_W-1:0] LOG_CODE_OUT
);
  localparam int FW = $clog2(FLASH_DIV + 1);
  // a zero divider would leave the flash counter without a wrap point
  if (FLASH_DIV < 1) begin : g_bad_div
    $error("FLASH_DIV must be at least one");
  end

  logic [CODE_W+4-1:0] raw_bus;
  logic [CODE_W+4-1:0] sync_bus;
  logic alarm_s, warn_s, surge_s, rst_s, wen_s;
  logic [CODE_W-1:0] code_s;
  // fault and reset pins cross into the clock domain before anything reads them
  assign raw_bus = {ALARM_DET_IN, WARN_DET_IN, SURGE_IN, RESET_CMD_IN, CODE_IN};
  pin_sync #(.WIDTH(CODE_W + 4)) u_sync (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .d_in(raw_bus),
    .q_out(sync_bus)
  );
  assign {alarm_s, warn_s, surge_s, rst_s, code_s} = sync_bus;
  // the menu setting is static logic on this clock
  assign wen_s = WARN_OUT_EN_IN;

  fault_state_t state_reg, state_next;
  logic is_alarm_reg, is_alarm_next;
  logic quiet_reg, quiet_next;
  logic [CODE_W-1:0] code_reg, code_next;
  logic rst_prev_reg;
  logic [FW-1:0] flash_cnt_reg;
  logic flash_reg;

  // suppressible warning band
  function automatic logic in_quiet(input logic [CODE_W-1:0] c);
    in_quiet = (c >= QUIET_LO) && (c <= QUIET_HI);
  endfunction : in_quiet

  wire fault_now = alarm_s | warn_s | surge_s;
  wire alarm_now = alarm_s | surge_s;
  wire rst_edge = rst_s & ~rst_prev_reg;
  wire new_quiet = ~alarm_now & ~wen_s & in_quiet(code_s);
  wire raise = (state_reg == ST_IDLE) && fault_now;

  // fault sequence: raise, silence, clear
  always_comb begin
    state_next = state_reg;
    is_alarm_next = is_alarm_reg;
    quiet_next = quiet_reg;
    code_next = code_reg;
    case (state_reg)
      ST_IDLE: begin
        if (fault_now) begin
          state_next = ST_RAISED;
          is_alarm_next = alarm_now;
          quiet_next = new_quiet;
          code_next = code_s;
        end
      end
      ST_RAISED: begin
        if (alarm_now && !is_alarm_reg) begin
          // an alarm outranks a pending warning
          is_alarm_next = 1'b1;
          quiet_next = 1'b0;
          code_next = code_s;
        end else if (rst_edge) begin
          if (quiet_reg) begin
            // quiet warning: first reset is the clearing one
            state_next = fault_now ? ST_RAISED : ST_IDLE;
          end else begin
            state_next = ST_SILENCED;
          end
        end
      end
      ST_SILENCED: begin
        if (rst_edge) begin
          // clearing reset needs the cause removed beforehand
          state_next = fault_now ? ST_RAISED : ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  wire active = (state_next != ST_IDLE);
  wire loud = active && !quiet_next;
  wire buzz = (state_next == ST_RAISED) && !quiet_next;
  wire relog = rst_edge && fault_now && (state_reg != ST_IDLE)
    && (state_next == ST_RAISED);
  wire [ACT_W-1:0] act = ACTION_MAP[code_next*ACT_W +: ACT_W];
  // brake engages on surge except while a warning is silenced, and holds until the alarm is cleared
  wire brake_next = active && is_alarm_next && (surge_s || BRAKE_OUT);

  // lamp flash timebase; free running keeps the logic small
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      flash_cnt_reg <= '0;
      flash_reg <= 1'b0;
    end else if (flash_cnt_reg == FW'(FLASH_DIV - 1)) begin
      flash_cnt_reg <= '0;
      flash_reg <= ~flash_reg;
    end else begin
      flash_cnt_reg <= flash_cnt_reg + 1'b1;
    end
  end

  // state and registered outputs
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_reg <= ST_IDLE;
      is_alarm_reg <= 1'b0;
      quiet_reg <= 1'b0;
      code_reg <= '0;
      rst_prev_reg <= 1'b0;
      LAMP_OUT <= 1'b0;
      ALARM_OUT <= 1'b0;
      WARNING_OUT <= 1'b0;
      BUZZER_OUT <= 1'b0;
      BRAKE_OUT <= 1'b0;
      DISPLAY_VALID_OUT <= 1'b0;
      DISPLAY_CODE_OUT <= '0;
      ACTION_OUT <= ACT_NONE;
      LOG_WR_OUT <= 1'b0;
      LOG_CODE_OUT <= '0;
    end else begin
      state_reg <= state_next;
      is_alarm_reg <= is_alarm_next;
      quiet_reg <= quiet_next;
      code_reg <= code_next;
      rst_prev_reg <= rst_s;
      // steady for alarms, flashing for warnings, dark for quiet warnings
      LAMP_OUT <= loud && (is_alarm_next || flash_reg);
      ALARM_OUT <= active && is_alarm_next;
      WARNING_OUT <= loud && !is_alarm_next;
      BUZZER_OUT <= buzz;
      BRAKE_OUT <= brake_next;
      DISPLAY_VALID_OUT <= active;
      DISPLAY_CODE_OUT <= active ? code_next : '0;
      ACTION_OUT <= (active && is_alarm_next) ? act : ACT_RUN;
      // one log entry per detection, quiet ones included
      LOG_WR_OUT <= raise || relog || (state_reg == ST_RAISED && alarm_now
        && !is_alarm_reg);
      LOG_CODE_OUT <= code_s;
    end
  end

  // checks
  sequence s_alarm_seen;
    state_reg == ST_IDLE && alarm_s;
  endsequence
  property p_alarm_out;
    @(posedge CLK_IN) disable iff (RST_IN)
    s_alarm_seen |=> ALARM_OUT && LAMP_OUT && BUZZER_OUT && DISPLAY_VALID_OUT;
  endproperty
  a_alarm_out: assert property (p_alarm_out) else $error("alarm outputs missing");
  property p_surge;
    @(posedge CLK_IN) disable iff (RST_IN)
    (state_reg == ST_IDLE && surge_s) |=> BRAKE_OUT && LAMP_OUT;
  endproperty
  a_surge: assert property (p_surge) else $error("surge not braked");
  property p_log;
    @(posedge CLK_IN) disable iff (RST_IN) raise |=> LOG_WR_OUT;
  endproperty
  a_log: assert property (p_log) else $error("fault not logged");
  property p_quiet;
    @(posedge CLK_IN) disable iff (RST_IN)
    quiet_reg |-> !WARNING_OUT && !BUZZER_OUT;
  endproperty
  a_quiet: assert property (p_quiet) else $error("quiet warning made noise");
  property p_silence;
    @(posedge CLK_IN) disable iff (RST_IN)
    (state_reg == ST_RAISED && !quiet_reg && rst_edge && !(alarm_now && !is_alarm_reg))
      |=> !BUZZER_OUT && DISPLAY_VALID_OUT;
  endproperty
  a_silence: assert property (p_silence) else $error("first reset wrong");
  property p_clear;
    @(posedge CLK_IN) disable iff (RST_IN)
    (state_reg == ST_SILENCED && rst_edge && !fault_now) |=> !ALARM_OUT && !LAMP_OUT;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");
  property p_again;
    @(posedge CLK_IN) disable iff (RST_IN)
    (state_reg == ST_SILENCED && rst_edge && fault_now) |=> BUZZER_OUT;
  endproperty
  a_again: assert property (p_again) else $error("fault not re-raised");
  // a held reset must not advance a silenced fault any further
  property p_once;
    @(posedge CLK_IN) disable iff (RST_IN)
    (state_reg == ST_SILENCED && rst_s && rst_prev_reg)
      |=> !BUZZER_OUT && DISPLAY_VALID_OUT;
  endproperty
  a_once: assert property (p_once) else $error("reset edge repeated");
  property p_quiet_clear;
    @(posedge CLK_IN) disable iff (RST_IN)
    (state_reg == ST_RAISED && quiet_reg && rst_edge && !fault_now) |=> !DISPLAY_VALID_OUT;
  endproperty
  a_quiet_clear: assert property (p_quiet_clear) else $error("quiet warning not cleared");
endmodule : pump_alarm_warning_manager
`default_nettype wire

// file: tb/operator_panel.sv
// operator and remote equipment model: fault pins and reset button
// assumes the bench calls its tasks; pins change on falling edges
`default_nettype none
module operator_panel (
  input wire logic clk_in,
  output logic alarm_out,
  output logic warn_out,
  output logic surge_out,
  output logic [6:0] code_out,
  output logic reset_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // all pins quiet at power up
  initial begin
    alarm_out = 1'b0;
    warn_out = 1'b0;
    surge_out = 1'b0;
    code_out = 7'h00;
    reset_out = 1'b0;
  end
  // fault cause appears as levels
  task automatic raise(input logic a, input logic w, input logic s, input logic [6:0] c);
    @(negedge clk_in);
    alarm_out = a;
    warn_out = w;
    surge_out = s;
    code_out = c;
  endtask : raise
  // operator fixes the cause before the clearing press
  task automatic remove();
    @(negedge clk_in);
    alarm_out = 1'b0;
    warn_out = 1'b0;
    surge_out = 1'b0;
  endtask : remove
  // held well past the sync depth, so a level trigger would repeat
  task automatic press();
    @(negedge clk_in);
    reset_out = 1'b1;
    repeat (8) @(negedge clk_in);
    reset_out = 1'b0;
    repeat (6) @(negedge clk_in);
  endtask : press
endmodule : operator_panel
`default_nettype wire

// file: tb/tb_top.sv
// fault manager bench: alarm, surge and warning sequences
// assumes operator_panel drives pins; short flash divider
`default_nettype none
module tb_top
  import fault_mgr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic warn_en = 1'b1;
  logic a_det, w_det, surge, rcmd, lamp, alarm, warn, buzz, brake, disp_v, log_wr;
  logic [CODE_W-1:0] code, disp_c, log_code;
  logic [ACT_W-1:0] action;
  logic [7:0] log_cnt = 8'h00;
  logic [CODE_W-1:0] log_last = '0;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  operator_panel op (.clk_in(clk), .alarm_out(a_det), .warn_out(w_det), .surge_out(surge),
    .code_out(code), .reset_out(rcmd));
  // code 5 maps to protective action 2
  pump_alarm_warning_manager #(.FLASH_DIV(4), .ACTION_MAP(256'h800)) DUT (.CLK_IN(clk),
    .RST_IN(rst), .ALARM_DET_IN(a_det), .WARN_DET_IN(w_det), .CODE_IN(code),
    .SURGE_IN(surge), .RESET_CMD_IN(rcmd), .WARN_OUT_EN_IN(warn_en), .LAMP_OUT(lamp),
    .ALARM_OUT(alarm), .WARNING_OUT(warn), .BUZZER_OUT(buzz), .BRAKE_OUT(brake),
    .DISPLAY_VALID_OUT(disp_v), .DISPLAY_CODE_OUT(disp_c), .ACTION_OUT(action),
    .LOG_WR_OUT(log_wr), .LOG_CODE_OUT(log_code));
  // log pulses counted; a stuck strobe shows as extra entries
  always @(posedge clk) begin
    if (log_wr === 1'b1) log_cnt <= log_cnt + 8'h01;
    if (log_wr === 1'b1) log_last <= log_code;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count = err_count + 1;
      results();
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // cycles with the lamp lit over ten samples
  task automatic lamp_scan(output logic [7:0] hi);
    hi = 8'h00;
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      if (lamp === 1'b1) hi = hi + 8'h01;
    end
  endtask : lamp_scan
  task automatic t_alarm();
    logic [7:0] n0, hi;
    n0 = log_cnt;
    op.raise(1'b1, 1'b0, 1'b0, 7'h05);
    repeat (6) @(negedge clk);
    lamp_scan(hi);
    chk("lamp_steady", 8'd10, hi);
    chk("alarm_buzz_warn", 8'h6, {alarm, buzz, warn});
    chk("display", {1'b1, 7'h05}, {disp_v, disp_c});
    chk("action", 8'h2, action);
    chk("log", {n0 + 8'h01}, log_cnt);
    chk("log_code", 8'h05, {1'b0, log_last});
    op.press();
    chk("silenced", 8'hd, {alarm, lamp, buzz, disp_v});
    op.remove();
    op.press();
    chk("cleared", 8'h0, {alarm, lamp, buzz, action});
  endtask : t_alarm
  task automatic t_surge();
    logic [7:0] n0;
    op.raise(1'b0, 1'b0, 1'b1, 7'h00);
    repeat (6) @(negedge clk);
    chk("brake_lamp", 8'h3, {brake, lamp});
    op.press();
    chk("brake_held", 8'h2, {brake, buzz});
    n0 = log_cnt;
    op.press();
    chk("again", 8'h7, {buzz, brake, lamp});
    chk("relog", {n0 + 8'h01}, log_cnt);
    op.remove();
    op.press();
    op.press();
    chk("brake_off", 8'h0, {brake, lamp});
  endtask : t_surge
  // an alarm on top of a raised warning takes over and is logged again
  task automatic t_upgrade();
    logic [7:0] n0;
    n0 = log_cnt;
    op.raise(1'b0, 1'b1, 1'b0, 7'd90);
    repeat (6) @(negedge clk);
    op.raise(1'b1, 1'b1, 1'b0, 7'h05);
    repeat (6) @(negedge clk);
    chk("up_outputs", 8'he, {alarm, lamp, buzz, warn});
    chk("up_display", {1'b1, 7'h05}, {disp_v, disp_c});
    chk("up_action", 8'h2, action);
    chk("up_log", n0 + 8'h02, log_cnt);
    chk("up_log_code", 8'h05, {1'b0, log_last});
    op.press();
    op.remove();
    op.press();
    chk("up_cleared", 8'h0, {alarm, lamp, buzz, warn, disp_v});
  endtask : t_upgrade
  task automatic t_warn(input logic [6:0] c, input logic en, input logic quiet);
    logic [7:0] n0, hi;
    @(negedge clk);
    warn_en = en;
    n0 = log_cnt;
    op.raise(1'b0, 1'b1, 1'b0, c);
    repeat (6) @(negedge clk);
    lamp_scan(hi);
    chk("flashing", {7'h0, !quiet}, {7'h0, hi > 0 && hi < 10});
    chk("lamp_dark", {7'h0, quiet}, {7'h0, hi == 8'h00});
    chk("warn_buzz", quiet ? 8'h0 : 8'h3, {warn, buzz});
    chk("display", {1'b1, c}, {disp_v, disp_c});
    chk("run", 8'h0, {alarm, brake, action});
    chk("log", {n0 + 8'h01}, log_cnt);
    chk("log_code", {1'b0, c}, {1'b0, log_last});
    if (!quiet) op.press();
    if (!quiet) chk("silenced", 8'h2, {warn, buzz});
    op.remove();
    op.press();
    chk("cleared", 8'h0, {warn, buzz, disp_v, brake, action});
  endtask : t_warn
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk("idle", 8'h0, {lamp, alarm, warn, buzz, brake, disp_v, log_wr});
    t_alarm();
    t_surge();
    t_upgrade();
    t_warn(7'd90, 1'b1, 1'b0);
    t_warn(7'd86, 1'b0, 1'b1);
    t_warn(7'd94, 1'b0, 1'b1);
    t_warn(7'd95, 1'b0, 1'b0);
    t_warn(7'd85, 1'b0, 1'b0);
    results();
  end
endmodule : tb_top
`default_nettype wire
